//--- hw/atc_core.sv
// Purpose: area trigger core with source select, run control, rate limit and deglitch
// Assumes: apb slave, zero wait states, inputs synchronous to pclk
// Notes: rate setting holds the trigger period in pclk cycles
`timescale 1ns/1ps
`include "atc_cfg.svh"
module atc_core
  import atc_pkg::*;
#(
  parameter logic [31:0] RATE_RESET = 32'(`ATC_CLK_HZ / `ATC_RATE_DEF_HZ)
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] pin_in,
  input wire logic sim_mode,
  input wire logic [31:0] sim_period,
  input wire logic [31:0] shaper_width [4],
  input wire logic [31:0] shaper_delay [4],
  input wire logic [31:0] shaper_downscale [4],
  input wire logic seq_req,
  output logic seq_grant,
  output logic trig_out,
  output logic shaper_run,
  output logic seq_clear
);
  atc_src_type src_q;
  atc_run_type run_q;
  atc_run_type run_prev_q;
  logic [31:0] rate_q;
  logic [15:0] deglitch_q;
  logic [3:0] ctrl_q;
  logic drop_flag_q;
  logic reject_flag_q;
  logic [7:0] pend_q;
  logic [31:0] gap_q;
  logic [3:0] pins_q;
  logic [3:0] deb_q;
  logic deb_prev_q;
  logic [15:0] deb_cnt_q [4];
  logic [15:0] deb_cycles;
  logic [3:0] shaper_ok;
  logic wr_en;
  logic rd_en;
  logic addr_hit;
  logic rate_valid;
  logic sw_wr;
  logic active;
  logic halted;
  logic restart;
  logic gap_ok;
  logic q_empty;
  logic ext_edge;
  logic in_pulse;
  logic direct;
  logic release_q;
  logic gen_fire;
  logic emit;
  logic enqueue;
  logic drop;
  logic [31:0] trig_gap_q;
  logic [15:0] hold1_q;

  // apb decode
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  always_comb
  begin
    case (paddr)
      `ATC_OFF_SOURCE, `ATC_OFF_RUN, `ATC_OFF_RATE, `ATC_OFF_DEGLITCH,
      `ATC_OFF_PINS, `ATC_OFF_CTRL, `ATC_OFF_STATUS: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_hit;

  // shaper spans against the requested period
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_span
      logic [31:0] span;
      assign span = (shaper_width[gi] > shaper_delay[gi]) ? shaper_width[gi] : shaper_delay[gi];
      assign shaper_ok[gi] = ({32'h0, pwdata} * {32'h0, shaper_downscale[gi]})
                             > {32'h0, span};
    end
  endgenerate
  assign rate_valid = (pwdata != 32'h0) && (&shaper_ok)
                      && !(sim_mode && (pwdata < sim_period));

  // configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_q <= ATC_SRC_GEN;
      run_q <= ATC_RUN_DRAIN;
      rate_q <= RATE_RESET;
      deglitch_q <= `ATC_DEGLITCH_RESET;
      ctrl_q <= `ATC_CTRL_RESET;
    end
    else if (wr_en)
    begin
      case (paddr)
        `ATC_OFF_SOURCE:
        begin
          if (pwdata[1:0] != 2'h3)
            src_q <= atc_src_type'(pwdata[1:0]);
        end
        `ATC_OFF_RUN:
        begin
          if (pwdata[1:0] != 2'h3)
            run_q <= atc_run_type'(pwdata[1:0]);
        end
        `ATC_OFF_RATE:
        begin
          if (rate_valid)
            rate_q <= pwdata;
        end
        `ATC_OFF_DEGLITCH: deglitch_q <= pwdata[15:0];
        `ATC_OFF_CTRL: ctrl_q <= pwdata[3:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  assign sw_wr = wr_en && (paddr == `ATC_OFF_CTRL) && pwdata[`ATC_CTRL_SW_TRIG];

  // sticky status, set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drop_flag_q <= 1'b0;
      reject_flag_q <= 1'b0;
    end
    else
    begin
      if (drop)
        drop_flag_q <= 1'b1;
      else if (wr_en && paddr == `ATC_OFF_STATUS && pwdata[`ATC_STAT_DROP])
        drop_flag_q <= 1'b0;
      if (wr_en && paddr == `ATC_OFF_RATE && !rate_valid)
        reject_flag_q <= 1'b1;
      else if (wr_en && paddr == `ATC_OFF_STATUS && pwdata[`ATC_STAT_REJECT])
        reject_flag_q <= 1'b0;
    end
  end

  // read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (rd_en)
    begin
      case (paddr)
        `ATC_OFF_SOURCE: prdata <= {30'h0, src_q};
        `ATC_OFF_RUN: prdata <= {30'h0, run_q};
        `ATC_OFF_RATE: prdata <= rate_q;
        `ATC_OFF_DEGLITCH: prdata <= {16'h0, deglitch_q};
        `ATC_OFF_PINS: prdata <= {28'h0, pins_q};
        `ATC_OFF_CTRL: prdata <= {28'h0, ctrl_q};
        `ATC_OFF_STATUS: prdata <= {16'h0, pend_q, 5'h0, !q_empty, reject_flag_q, drop_flag_q};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // deglitch of the four inputs with one shared time
  assign deb_cycles = 16'((32'(deglitch_q) * `ATC_TICK_PS + `ATC_CLK_PERIOD_PS - 1)
                          / `ATC_CLK_PERIOD_PS);
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_deb
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          deb_q[gi] <= 1'b0;
          deb_cnt_q[gi] <= 16'h0;
        end
        else if (pin_in[gi] == deb_q[gi])
          deb_cnt_q[gi] <= 16'h0;
        else if (deb_cnt_q[gi] >= deb_cycles)
        begin
          deb_q[gi] <= pin_in[gi];
          deb_cnt_q[gi] <= 16'h0;
        end
        else
          deb_cnt_q[gi] <= deb_cnt_q[gi] + 16'h1;
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pins_q <= 4'h0;
      deb_prev_q <= 1'b0;
    end
    else
    begin
      pins_q <= pin_in;
      deb_prev_q <= deb_q[ctrl_q[`ATC_CTRL_SEL_HI:`ATC_CTRL_SEL_LO]];
    end
  end

  // trigger path
  assign active = (run_q == ATC_RUN_ACTIVE);
  assign halted = (run_q == ATC_RUN_ABRUPT);
  assign restart = active && (run_prev_q != ATC_RUN_ACTIVE);
  assign gap_ok = (gap_q >= rate_q - 32'h1);
  assign q_empty = (pend_q == 8'h0);
  assign ext_edge = ctrl_q[`ATC_CTRL_POL_LOW]
                    ? (!deb_q[ctrl_q[`ATC_CTRL_SEL_HI:`ATC_CTRL_SEL_LO]] && deb_prev_q)
                    : (deb_q[ctrl_q[`ATC_CTRL_SEL_HI:`ATC_CTRL_SEL_LO]] && !deb_prev_q);
  assign in_pulse = active && ((src_q == ATC_SRC_EXT && ext_edge)
                    || (src_q == ATC_SRC_SW && sw_wr));
  assign direct = in_pulse && q_empty && gap_ok && !restart;
  assign release_q = !halted && !q_empty && gap_ok && !restart;
  assign gen_fire = active && (src_q == ATC_SRC_GEN) && gap_ok;
  assign emit = direct || release_q || gen_fire;
  assign enqueue = in_pulse && !direct && !restart && ctrl_q[`ATC_CTRL_QUEUE_EN]
                   && (pend_q != 8'hFF);
  assign drop = in_pulse && !direct && !enqueue;
  assign seq_grant = seq_req && gap_ok && !halted && !emit && !restart;
  assign shaper_run = !halted;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_prev_q <= ATC_RUN_DRAIN;
    else
      run_prev_q <= run_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_q <= 8'h0;
    else if (restart)
      pend_q <= 8'h0;
    else
      pend_q <= pend_q + {7'h0, enqueue} - {7'h0, release_q};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gap_q <= 32'hFFFFFFFF;
    else if (halted)
      gap_q <= gap_q;
    else if (emit || seq_grant)
      gap_q <= 32'h0;
    else if (gap_q != 32'hFFFFFFFF)
      gap_q <= gap_q + 32'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_out <= 1'b0;
      seq_clear <= 1'b0;
    end
    else
    begin
      trig_out <= emit && !halted;
      seq_clear <= restart;
    end
  end

  // helpers watch pin 1 and the output apart from the trigger logic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trig_gap_q <= 32'hFFFFFFFF;
    else if (trig_out)
      trig_gap_q <= 32'h0;
    else if (trig_gap_q != 32'hFFFFFFFF)
      trig_gap_q <= trig_gap_q + 32'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold1_q <= 16'h0;
    else if (pin_in[1] != pins_q[1])
      hold1_q <= 16'h1;
    else if (hold1_q != 16'hFFFF)
      hold1_q <= hold1_q + 16'h1;
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  rate_limit_a: assert property (trig_out |-> trig_gap_q >= rate_q - 32'h1)
    else $error("trigger emitted inside the rate period");
  drop_flag_a: assert property (drop |=> drop_flag_q)
    else $error("dropped pulse did not set the flag");
  gen_ignore_a: assert property (src_q == ATC_SRC_GEN |-> !in_pulse && !drop)
    else $error("input pulse used in generator mode");
  gen_period_a: assert property (active && src_q == ATC_SRC_GEN && gap_ok
    |=> trig_out)
    else $error("generator missed its period");
  queue_hold_a: assert property (enqueue && !release_q |=> pend_q == $past(pend_q) + 8'h1)
    else $error("queued pulse not counted");
  seq_rate_a: assert property (seq_grant |-> gap_ok && !emit)
    else $error("sequencer granted inside the rate period");
  rate_reject_a: assert property (wr_en && paddr == `ATC_OFF_RATE && !rate_valid
    |=> $stable(rate_q) && reject_flag_q)
    else $error("invalid rate accepted");
  drain_input_a: assert property (run_q == ATC_RUN_DRAIN |-> !in_pulse && !gen_fire)
    else $error("new pulse taken in draining stop");
  abrupt_halt_a: assert property (halted |=> !trig_out && !shaper_run ##0 $stable(pend_q)
    or !halted)
    else $error("activity during abrupt stop");
  restart_clear_a: assert property (restart |=> pend_q == 8'h0 && seq_clear)
    else $error("queue not emptied on restart");
  deglitch_hold_a: assert property ($changed(deb_q[0]) |-> $past(pin_in[0]) == deb_q[0]
    && $past(deb_cnt_q[0]) >= $past(deb_cycles))
    else $error("input level accepted before stable time");
  src_code_a: assert property (wr_en && paddr == `ATC_OFF_SOURCE && pwdata[1:0] == 2'h3
    |=> $stable(src_q))
    else $error("illegal source code stored");
  deglitch_wait_a: assert property ($changed(deb_q[1])
    |-> $past(hold1_q) >= $past(deb_cycles))
    else $error("input 1 accepted before it was stable");
  sw_pulse_a: assert property (src_q == ATC_SRC_SW && sw_wr && active && q_empty
    && gap_ok && !restart |=> trig_out)
    else $error("software pulse not emitted");
  pin_view_a: assert property ($past(presetn) |-> pins_q == $past(pin_in))
    else $error("pin view does not follow the inputs");
  abrupt_freeze_a: assert property (halted |=> $stable(gap_q))
    else $error("rate gap moved during abrupt stop");

  gen_run_c: cover property (gen_fire ##[1:50] gen_fire);
  ext_drop_c: cover property (src_q == ATC_SRC_EXT && drop);
  queue_drain_c: cover property (enqueue ##[1:100] release_q);
  restart_c: cover property (restart);
  low_pol_c: cover property (ctrl_q[`ATC_CTRL_POL_LOW] && ext_edge);
endmodule

//--- include/atc_cfg.svh
// Purpose: constants of the area trigger core
// Assumes: 25 MHz pclk
// Notes: offsets are byte addresses on the apb bus
`ifndef ATC_CFG_SVH
`define ATC_CFG_SVH
`define ATC_OFF_SOURCE 8'h00
`define ATC_OFF_RUN 8'h04
`define ATC_OFF_RATE 8'h08
`define ATC_OFF_DEGLITCH 8'h0C
`define ATC_OFF_PINS 8'h10
`define ATC_OFF_CTRL 8'h14
`define ATC_OFF_STATUS 8'h18
`define ATC_SRC_GEN 2'h0
`define ATC_SRC_EXT 2'h1
`define ATC_SRC_SW 2'h2
`define ATC_RUN_ACTIVE 2'h0
`define ATC_RUN_ABRUPT 2'h1
`define ATC_RUN_DRAIN 2'h2
`define ATC_CTRL_SEL_LO 0
`define ATC_CTRL_SEL_HI 1
`define ATC_CTRL_POL_LOW 2
`define ATC_CTRL_QUEUE_EN 3
`define ATC_CTRL_SW_TRIG 4
`define ATC_STAT_DROP 0
`define ATC_STAT_REJECT 1
`define ATC_STAT_BUSY 2
`define ATC_STAT_CNT_LO 8
`define ATC_STAT_CNT_HI 15
`define ATC_CLK_HZ 25000000
`define ATC_CLK_PERIOD_PS 40000
`define ATC_TICK_PS 3200
`define ATC_DEGLITCH_DEF_NS 1000
`define ATC_DEGLITCH_RESET 16'h0138
`define ATC_RATE_DEF_HZ 8
`define ATC_CTRL_RESET 4'h0
`endif

//--- include/atc_pkg.sv
// Purpose: types of the area trigger core
// Assumes: atc_cfg.svh on the include path
// Notes: codes come from the constants header
`include "atc_cfg.svh"
package atc_pkg;
  typedef enum logic [1:0] {
    ATC_SRC_GEN = `ATC_SRC_GEN,
    ATC_SRC_EXT = `ATC_SRC_EXT,
    ATC_SRC_SW = `ATC_SRC_SW
  } atc_src_type;
  typedef enum logic [1:0] {
    ATC_RUN_ACTIVE = `ATC_RUN_ACTIVE,
    ATC_RUN_ABRUPT = `ATC_RUN_ABRUPT,
    ATC_RUN_DRAIN = `ATC_RUN_DRAIN
  } atc_run_type;
endpackage

//--- tb/atc_far_end.sv
// Purpose: far-side model of trigger inputs and camera lines
// Assumes: drives just after the rising edge of pclk
// Notes: counts trigger, grant and clear pulses
`timescale 1ns/1ps
module atc_far_end
(
  input wire logic pclk,
  input wire logic trig_out,
  input wire logic seq_grant,
  input wire logic seq_clear,
  output logic [3:0] pin_in,
  output logic seq_req
);
  int cyc = 0;
  int last = 0;
  int min_gap = 1000;
  int trig_cnt = 0;
  int grant_cnt = 0;
  int clr_cnt = 0;
  initial
  begin
    pin_in = 4'h0;
    seq_req = 1'b0;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (trig_out === 1'b1)
    begin
      trig_cnt <= trig_cnt + 1;
      last <= cyc;
      if (cyc - last < min_gap)
        min_gap <= cyc - last;
    end
    if (seq_grant === 1'b1)
      grant_cnt <= grant_cnt + 1;
    if (seq_clear === 1'b1)
      clr_cnt <= clr_cnt + 1;
  end
  task automatic pulses(input int n, input int p, input int hi, input int lo);
    repeat (n)
    begin
      pin_in[p] <= 1'b1;
      repeat (hi) @(posedge pclk);
      pin_in[p] <= 1'b0;
      repeat (lo) @(posedge pclk);
    end
  endtask
  task automatic levels(input logic [3:0] v);
    pin_in <= v;
  endtask
  task automatic set_req(input logic v);
    seq_req <= v;
  endtask
endmodule

//--- tb/tb_atc_core.sv
// Purpose: self-checking bench of the area trigger core
// Assumes: rate parameter shortened to 10 cycles
// Notes: apb master tasks and a far-side model
`timescale 1ns/1ps
`include "atc_cfg.svh"
module tb_atc_core;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sim_mode = 1'b0;
  logic [31:0] sim_period = 32'h0;
  logic [31:0] sw [4] = '{default: 32'h1};
  logic [31:0] sd [4] = '{default: 32'h1};
  logic [31:0] sds [4] = '{default: 32'h1};
  logic [31:0] prdata, rd;
  logic [3:0] pin_in;
  logic pready, pslverr, err, seq_req, seq_grant, trig_out, shaper_run, seq_clear;
  int failures = 0;
  int cmp_count = 0;
  int b;
  int t0;
  initial
    forever #20 pclk = ~pclk;
  atc_core #(.RATE_RESET(32'hA)) u_atc_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .sim_mode(sim_mode),
    .sim_period(sim_period), .shaper_width(sw), .shaper_delay(sd), .shaper_downscale(sds),
    .seq_req(seq_req), .seq_grant(seq_grant), .trig_out(trig_out), .shaper_run(shaper_run),
    .seq_clear(seq_clear));
  atc_far_end u_atc_far_end (.pclk(pclk), .trig_out(trig_out), .seq_grant(seq_grant),
    .seq_clear(seq_clear), .pin_in(pin_in), .seq_req(seq_req));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge pclk);
    failures++;
    conclude();
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk("source", `ATC_OFF_SOURCE, 32'h0);
    rchk("run", `ATC_OFF_RUN, 32'h2);
    rchk("rate", `ATC_OFF_RATE, 32'hA);
    rchk("deglitch", `ATC_OFF_DEGLITCH, 32'h138);
    rchk("unmapped", 8'h1C, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    for (int i = 2; i >= 0; i--)
    begin
      wr(`ATC_OFF_SOURCE, 32'(i));
      rchk("source", `ATC_OFF_SOURCE, 32'(i));
    end
    u_atc_far_end.levels(4'hA);
    rchk("pins", `ATC_OFF_PINS, 32'hA);
    u_atc_far_end.levels(4'h0);
    $display("test registers done");
    wr(`ATC_OFF_RUN, 32'h0);
    repeat (15) @(posedge pclk);
    b = u_atc_far_end.trig_cnt;
    u_atc_far_end.min_gap = 1000;
    repeat (60) @(posedge pclk);
    chk("gen gap", 32'hA, 32'(u_atc_far_end.min_gap));
    chk("gen count", 32'h6, 32'(u_atc_far_end.trig_cnt - b));
    $display("test generator done");
    wr(`ATC_OFF_SOURCE, 32'h1);
    wr(`ATC_OFF_CTRL, 32'h0);
    wr(`ATC_OFF_DEGLITCH, 32'h0);
    repeat (20) @(posedge pclk);
    b = u_atc_far_end.trig_cnt;
    u_atc_far_end.min_gap = 1000;
    u_atc_far_end.pulses(4, 0, 2, 2);
    repeat (20) @(posedge pclk);
    chk("drop count", 32'h2, 32'(u_atc_far_end.trig_cnt - b));
    rchk("drop flag", `ATC_OFF_STATUS, 32'h1);
    wr(`ATC_OFF_STATUS, 32'h3);
    rchk("flag clear", `ATC_OFF_STATUS, 32'h0);
    $display("test drop done");
    wr(`ATC_OFF_CTRL, 32'h8);
    b = u_atc_far_end.trig_cnt;
    u_atc_far_end.pulses(4, 0, 2, 2);
    repeat (50) @(posedge pclk);
    chk("queue count", 32'h4, 32'(u_atc_far_end.trig_cnt - b));
    chk("queue gap", 32'h1, 32'(u_atc_far_end.min_gap >= 10));
    b = u_atc_far_end.trig_cnt;
    u_atc_far_end.pulses(3, 0, 2, 2);
    wr(`ATC_OFF_RUN, 32'h2);
    u_atc_far_end.pulses(3, 0, 2, 2);
    repeat (40) @(posedge pclk);
    chk("drain count", 32'h3, 32'(u_atc_far_end.trig_cnt - b));
    $display("test queue done");
    wr(`ATC_OFF_RUN, 32'h1);
    @(posedge pclk);
    chk("abrupt run", 32'h0, {31'h0, shaper_run});
    b = u_atc_far_end.trig_cnt;
    u_atc_far_end.pulses(2, 0, 2, 12);
    chk("abrupt count", 32'h0, 32'(u_atc_far_end.trig_cnt - b));
    b = u_atc_far_end.clr_cnt;
    wr(`ATC_OFF_RUN, 32'h0);
    repeat (3) @(posedge pclk);
    chk("restart clear", 32'h1, 32'(u_atc_far_end.clr_cnt - b));
    chk("active run", 32'h1, {31'h0, shaper_run});
    $display("test run control done");
    wr(`ATC_OFF_SOURCE, 32'h2);
    b = u_atc_far_end.trig_cnt;
    wr(`ATC_OFF_CTRL, 32'h10);
    repeat (5) @(posedge pclk);
    chk("sw count", 32'h1, 32'(u_atc_far_end.trig_cnt - b));
    b = u_atc_far_end.grant_cnt;
    u_atc_far_end.set_req(1'b1);
    repeat (50) @(posedge pclk);
    u_atc_far_end.set_req(1'b0);
    b = u_atc_far_end.grant_cnt - b;
    chk("grants", 32'h1, 32'(b >= 4 && b <= 6));
    $display("test software done");
    wr(`ATC_OFF_SOURCE, 32'h1);
    wr(`ATC_OFF_CTRL, 32'h1);
    wr(`ATC_OFF_DEGLITCH, 32'h138);
    b = u_atc_far_end.trig_cnt;
    u_atc_far_end.pulses(1, 1, 10, 40);
    chk("glitch", 32'h0, 32'(u_atc_far_end.trig_cnt - b));
    b = u_atc_far_end.trig_cnt;
    t0 = u_atc_far_end.cyc;
    u_atc_far_end.pulses(1, 1, 40, 10);
    chk("steady", 32'h1, 32'(u_atc_far_end.trig_cnt - b));
    chk("delay", 32'h1, 32'(u_atc_far_end.last - t0 >= 26 && u_atc_far_end.last - t0 <= 29));
    $display("test deglitch done");
    wr(`ATC_OFF_RATE, 32'h0);
    rchk("rate zero", `ATC_OFF_RATE, 32'hA);
    sim_mode <= 1'b1;
    sim_period <= 32'h14;
    wr(`ATC_OFF_RATE, 32'hF);
    rchk("rate sim", `ATC_OFF_RATE, 32'hA);
    rchk("reject flag", `ATC_OFF_STATUS, 32'h2);
    sim_mode <= 1'b0;
    sw[2] <= 32'h1E;
    wr(`ATC_OFF_RATE, 32'h1E);
    rchk("rate shaper", `ATC_OFF_RATE, 32'hA);
    wr(`ATC_OFF_RATE, 32'h1F);
    rchk("rate ok", `ATC_OFF_RATE, 32'h1F);
    $display("test rate done");
    wr(`ATC_OFF_CTRL, 32'h6);
    wr(`ATC_OFF_DEGLITCH, 32'h0);
    b = u_atc_far_end.trig_cnt;
    t0 = u_atc_far_end.cyc;
    u_atc_far_end.pulses(1, 2, 5, 5);
    chk("low count", 32'h1, 32'(u_atc_far_end.trig_cnt - b));
    chk("low edge", 32'h1, 32'(u_atc_far_end.last - t0 >= 7 && u_atc_far_end.last - t0 <= 9));
    $display("test polarity done");
    conclude();
  end
endmodule
